//--- gp_regs_pkg.sv
`default_nettype none
package gp_regs_pkg;
   // Register byte offsets inside the pipeline window
   localparam logic [15:0] OFS_DEST      = 16'h8100;
   localparam logic [15:0] OFS_SIZE      = 16'h8104;
   localparam logic [15:0] OFS_SRC_ERR   = 16'h8108;
   localparam logic [15:0] OFS_SRC_COLOR = 16'h810c;
   localparam logic [15:0] OFS_PAT_COL01 = 16'h8110;
   localparam logic [15:0] OFS_PAT_COL23 = 16'h8114;
   localparam logic [15:0] OFS_PAT_W0    = 16'h8120;
   localparam logic [15:0] OFS_PAT_W1    = 16'h8124;
   localparam logic [15:0] OFS_PAT_W2    = 16'h8128;
   localparam logic [15:0] OFS_PAT_W3    = 16'h812c;
   localparam logic [15:0] OFS_VGA_WR    = 16'h8140;
   localparam logic [15:0] OFS_VGA_RD    = 16'h8144;
   localparam logic [15:0] OFS_RASTER    = 16'h8200;
   localparam logic [15:0] OFS_VECTOR    = 16'h8204;
   localparam logic [15:0] OFS_BLT       = 16'h8208;
   localparam logic [15:0] OFS_STATE     = 16'h820c;
   localparam logic [15:0] OFS_VGA_BASE  = 16'h8210;
   localparam logic [15:0] OFS_VGA_LATCH = 16'h8214;

   // Reset value of every register
   localparam logic [31:0] REG_RESET     = 32'h0000_0000;

   // Field positions
   localparam int          COORD_Y_LSB   = 16;
   localparam int          ROP_LSB       = 0;
   localparam int          PAT_MODE_LSB  = 8;
   localparam logic [1:0]  PAT_MODE_COLOR = 2'h3;
   localparam int          STATUS_W      = 8;
   localparam int          ST_BUSY       = 0;
   localparam int          ST_VECTOR     = 1;
   localparam int          ST_BLT        = 2;

   // Kind of operation held by the engine
   typedef enum logic [1:0] {OP_IDLE, OP_VECTOR, OP_BLT} op_t;
endpackage
`default_nettype wire

//--- graphics_pipe_register_bank.sv
`default_nettype none
// Function
// - Four words form 128-bit pattern in order
// - Vector mode write launches line draw
// - Transfer mode write launches block transfer
// - Status register low byte holds status
// - VGA base gives offset into graphics memory
// - Display latch readable and writable by software
// - Destination bits 31:16 signed Y
// - Destination bits 15:0 signed X
// - Raster mode steers pixel manipulation
// - VGA read control steers read path
// - ROP bit indexed by pattern, source, destination
// - Pattern mode 11b selects colour pattern
module graphics_pipe_register_bank
   import gp_regs_pkg::*;
#(
   parameter int ADDR_W = 16,            // Offset width
   parameter int PIX_W  = 16             // ROP datapath width
) (
   input  wire logic                core_clk,      // Core clock
   input  wire logic                rst,           // Async reset, high
   input  wire logic                wr_en,         // Register write strobe
   input  wire logic                rd_en,         // Register read strobe
   input  wire logic [ADDR_W-1:0]   addr,          // Byte offset
   input  wire logic [31:0]         wdata,         // Write data
   output logic      [31:0]         rdata,         // Read data
   output logic                     rd_valid,      // Read data valid pulse
   input  wire logic                engine_done,   // Engine finished pulse
   input  wire logic                latch_load,    // VGA loads latch
   input  wire logic [31:0]         latch_in,      // VGA latch value
   input  wire logic [PIX_W-1:0]    pat_pix,       // Pattern bits
   input  wire logic [PIX_W-1:0]    src_pix,       // Source bits
   input  wire logic [PIX_W-1:0]    dst_pix,       // Destination bits
   output logic      [PIX_W-1:0]    rop_pix,       // Combined output
   output logic                     vector_start,  // Line draw launch
   output logic                     blt_start,     // Block transfer launch
   output logic                     engine_busy,   // Operation running
   output logic signed [15:0]       dest_y,        // Destination Y
   output logic signed [15:0]       dest_x,        // Destination X
   output logic      [31:0]         geom_size,     // Width/height, length
   output logic      [31:0]         geom_src,      // Source or errors
   output logic      [31:0]         src_colors,    // Source colours
   output logic      [63:0]         pat_colors,    // Pattern colours
   output logic      [127:0]        pattern,       // Full pattern
   output logic                     color_pattern, // Colour pattern mode
   output logic      [31:0]         raster_mode,   // Raster control
   output logic      [31:0]         vga_wr_ctrl,   // VGA write path
   output logic      [31:0]         vga_rd_ctrl,   // VGA read path
   output logic      [31:0]         vga_base,      // VGA memory offset
   output logic      [31:0]         vga_latch      // Display latch
);
   import gp_regs_pkg::*;

   if (ADDR_W < 16) begin : g_chk_addr
      $error("ADDR_W must be at least 16");
   end
   if (PIX_W < 1) begin : g_chk_pix
      $error("PIX_W must be positive");
   end

   // Offset match, used by every decode
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [15:0] ofs);
      hit = (a == ADDR_W'(ofs));
   endfunction

   // One output bit from the eight-bit code
   function automatic logic rop_bit(input logic [7:0] rop, input logic p,
                                    input logic s, input logic d);
      rop_bit = rop[{p, s, d}];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register file
   logic [31:0]  dest, vec_mode, blt_mode, state_cfg;
   logic [31:0]  next_dest, next_size, next_src, next_scol;
   logic [63:0]  next_pcol;
   logic [127:0] next_pattern;
   logic [31:0]  next_vga_wr, next_vga_rd, next_raster, next_vec_mode;
   logic [31:0]  next_blt_mode, next_state_cfg, next_vga_base;
   logic [31:0]  next_vga_latch;

   // Software writes; latch loads from VGA yield to a software write
   always_comb begin
      next_dest      = dest;
      next_size      = geom_size;
      next_src       = geom_src;
      next_scol      = src_colors;
      next_pcol      = pat_colors;
      next_pattern   = pattern;
      next_vga_wr    = vga_wr_ctrl;
      next_vga_rd    = vga_rd_ctrl;
      next_raster    = raster_mode;
      next_vec_mode  = vec_mode;
      next_blt_mode  = blt_mode;
      next_state_cfg = state_cfg;
      next_vga_base  = vga_base;
      next_vga_latch = latch_load ? latch_in : vga_latch;
      if (wr_en) begin
         if (hit(addr, OFS_DEST))      next_dest = wdata;
         if (hit(addr, OFS_SIZE))      next_size = wdata;
         if (hit(addr, OFS_SRC_ERR))   next_src = wdata;
         if (hit(addr, OFS_SRC_COLOR)) next_scol = wdata;
         if (hit(addr, OFS_PAT_COL01)) next_pcol[31:0] = wdata;
         if (hit(addr, OFS_PAT_COL23)) next_pcol[63:32] = wdata;
         if (hit(addr, OFS_PAT_W0))    next_pattern[31:0] = wdata;
         if (hit(addr, OFS_PAT_W1))    next_pattern[63:32] = wdata;
         if (hit(addr, OFS_PAT_W2))    next_pattern[95:64] = wdata;
         if (hit(addr, OFS_PAT_W3))    next_pattern[127:96] = wdata;
         if (hit(addr, OFS_VGA_WR))    next_vga_wr = wdata;
         if (hit(addr, OFS_VGA_RD))    next_vga_rd = wdata;
         if (hit(addr, OFS_RASTER))    next_raster = wdata;
         if (hit(addr, OFS_VECTOR))    next_vec_mode = wdata;
         if (hit(addr, OFS_BLT))       next_blt_mode = wdata;
         if (hit(addr, OFS_STATE))     next_state_cfg = wdata;
         if (hit(addr, OFS_VGA_BASE))  next_vga_base = wdata;
         if (hit(addr, OFS_VGA_LATCH)) next_vga_latch = wdata;
      end
   end

   // Registered copies; unknown documented defaults are cleared here too
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dest        <= REG_RESET;
         geom_size   <= REG_RESET;
         geom_src    <= REG_RESET;
         src_colors  <= REG_RESET;
         pat_colors  <= {2{REG_RESET}};
         pattern     <= {4{REG_RESET}};
         vga_wr_ctrl <= REG_RESET;
         vga_rd_ctrl <= REG_RESET;
         raster_mode <= REG_RESET;
         vec_mode    <= REG_RESET;
         blt_mode    <= REG_RESET;
         state_cfg   <= REG_RESET;
         vga_base    <= REG_RESET;
         vga_latch   <= REG_RESET;
      end else begin
         dest        <= next_dest;
         geom_size   <= next_size;
         geom_src    <= next_src;
         src_colors  <= next_scol;
         pat_colors  <= next_pcol;
         pattern     <= next_pattern;
         vga_wr_ctrl <= next_vga_wr;
         vga_rd_ctrl <= next_vga_rd;
         raster_mode <= next_raster;
         vec_mode    <= next_vec_mode;
         blt_mode    <= next_blt_mode;
         state_cfg   <= next_state_cfg;
         vga_base    <= next_vga_base;
         vga_latch   <= next_vga_latch;
      end
   end

   // Field views of the registers
   assign dest_y = signed'(dest[31:COORD_Y_LSB]);
   assign dest_x = signed'(dest[COORD_Y_LSB-1:0]);
   assign color_pattern =
      (raster_mode[PAT_MODE_LSB +: 2] == PAT_MODE_COLOR);

   ////////////////////////////////////////////////////////////////////////
   // Launch and engine tracking
   op_t  op, next_op;
   logic next_vstart, next_bstart;

   // A launch in the done cycle wins so the new operation is not lost
   always_comb begin
      next_vstart = wr_en && hit(addr, OFS_VECTOR);
      next_bstart = wr_en && hit(addr, OFS_BLT) && !next_vstart;
      next_op     = engine_done ? OP_IDLE : op;
      if (next_vstart) begin
         next_op = OP_VECTOR;
      end else if (next_bstart) begin
         next_op = OP_BLT;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         op           <= OP_IDLE;
         vector_start <= 1'b0;
         blt_start    <= 1'b0;
      end else begin
         op           <= next_op;
         vector_start <= next_vstart;
         blt_start    <= next_bstart;
      end
   end

   assign engine_busy = (op != OP_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Read port
   logic [STATUS_W-1:0] status;
   logic [31:0]         next_rdata;
   logic                next_rd_valid;

   // Status byte is live engine state, not stored software data
   always_comb begin
      status            = '0;
      status[ST_BUSY]   = engine_busy;
      status[ST_VECTOR] = (op == OP_VECTOR);
      status[ST_BLT]    = (op == OP_BLT);
      next_rd_valid     = rd_en;
      next_rdata        = 32'h0000_0000;  // Unmapped offsets read zero
      if (rd_en) begin
         if (hit(addr, OFS_DEST))      next_rdata = dest;
         if (hit(addr, OFS_SIZE))      next_rdata = geom_size;
         if (hit(addr, OFS_SRC_ERR))   next_rdata = geom_src;
         if (hit(addr, OFS_SRC_COLOR)) next_rdata = src_colors;
         if (hit(addr, OFS_PAT_COL01)) next_rdata = pat_colors[31:0];
         if (hit(addr, OFS_PAT_COL23)) next_rdata = pat_colors[63:32];
         if (hit(addr, OFS_PAT_W0))    next_rdata = pattern[31:0];
         if (hit(addr, OFS_PAT_W1))    next_rdata = pattern[63:32];
         if (hit(addr, OFS_PAT_W2))    next_rdata = pattern[95:64];
         if (hit(addr, OFS_PAT_W3))    next_rdata = pattern[127:96];
         if (hit(addr, OFS_VGA_WR))    next_rdata = vga_wr_ctrl;
         if (hit(addr, OFS_VGA_RD))    next_rdata = vga_rd_ctrl;
         if (hit(addr, OFS_RASTER))    next_rdata = raster_mode;
         if (hit(addr, OFS_VECTOR))    next_rdata = vec_mode;
         if (hit(addr, OFS_BLT))       next_rdata = blt_mode;
         if (hit(addr, OFS_STATE))
            next_rdata = {state_cfg[31:STATUS_W], status};
         if (hit(addr, OFS_VGA_BASE))  next_rdata = vga_base;
         if (hit(addr, OFS_VGA_LATCH)) next_rdata = vga_latch;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata    <= REG_RESET;
         rd_valid <= 1'b0;
      end else begin
         rdata    <= next_rdata;
         rd_valid <= next_rd_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Raster operation on the pixel lanes, registered for timing
   logic [PIX_W-1:0] next_rop_pix;

   always_comb begin
      next_rop_pix = '0;
      for (int i = 0; i < PIX_W; i++) begin
         next_rop_pix[i] = rop_bit(raster_mode[ROP_LSB +: 8], pat_pix[i],
                                   src_pix[i], dst_pix[i]);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) rop_pix <= '0;
      else     rop_pix <= next_rop_pix;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_vec_write;
      wr_en && hit(addr, OFS_VECTOR);
   endsequence
   sequence s_blt_write;
      wr_en && hit(addr, OFS_BLT) && !hit(addr, OFS_VECTOR);
   endsequence

   a_vector_launch: assert property (s_vec_write |=> vector_start &&
      op == OP_VECTOR) else $error("vector write did not launch");
   a_blt_launch: assert property (s_blt_write |=> blt_start ##0
      engine_busy) else $error("transfer write did not launch");
   a_busy_held: assert property (vector_start && !engine_done
      |=> engine_busy) else $error("busy dropped without done");
   a_status_read: assert property (rd_en && hit(addr, OFS_STATE)
      |=> rd_valid && rdata[ST_BUSY] == $past(engine_busy))
      else $error("status byte does not show busy");
   a_pattern_top: assert property (wr_en && hit(addr, OFS_PAT_W3)
      |=> pattern[127:96] == $past(wdata)) else $error("pattern word 3");
   a_pattern_mid: assert property (wr_en && hit(addr, OFS_PAT_W1)
      |=> pattern[63:32] == $past(wdata)) else $error("pattern word 1");
   a_dest_fields: assert property (wr_en && hit(addr, OFS_DEST)
      |=> dest_y == $past(wdata[31:16]) && dest_x == $past(wdata[15:0]))
      else $error("destination fields wrong");
   a_vga_base_rb: assert property (rd_en && hit(addr, OFS_VGA_BASE)
      |=> rdata == $past(vga_base)) else $error("base readback wrong");
   a_color_mode: assert property (wr_en && hit(addr, OFS_RASTER)
      |=> color_pattern == ($past(wdata[9:8]) == 2'h3))
      else $error("colour pattern mode wrong");
   a_rop_result: assert property (##1 rop_pix[0] ==
      $past(raster_mode[{pat_pix[0], src_pix[0], dst_pix[0]}]))
      else $error("rop bit wrong");
endmodule
`default_nettype wire

//--- testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import gp_regs_pkg::*;

   `define CHK(got, exp) \
      begin \
         total_checks++; \
         if ((got) !== (exp)) begin \
            n_fail++; \
            $display("Error at %0t: got %h want %h", $time, got, exp); \
         end \
      end

   ////////////////////////////////////////////////////////////////////////
   logic               core_clk     = 1'b0;
   logic               rst          = 1'b1;
   logic               wr_en        = 1'b0;
   logic               rd_en        = 1'b0;
   logic [15:0]        addr         = 16'h0000;
   logic [31:0]        wdata        = 32'h0000_0000;
   logic               engine_done  = 1'b0;
   logic               latch_load   = 1'b0;
   logic [31:0]        latch_in     = 32'h0000_0000;
   logic [15:0]        pat_pix      = 16'h0000;
   logic [15:0]        src_pix      = 16'h0000;
   logic [15:0]        dst_pix      = 16'h0000;
   logic [31:0]        rdata, geom_size, geom_src, src_colors, raster_mode;
   logic [31:0]        vga_wr_ctrl, vga_rd_ctrl, vga_base, vga_latch;
   logic               rd_valid, vector_start, blt_start, engine_busy;
   logic               color_pattern;
   logic [15:0]        rop_pix;
   logic signed [15:0] dest_y, dest_x;
   logic [63:0]        pat_colors;
   logic [127:0]       pattern;
   logic [31:0]        lfsr         = 32'hcbb6b467;
   logic [31:0]        cfg          = 32'h0000_0000;
   int                 n_fail       = 0;
   int                 total_checks = 0;

   // First fifteen are plain storage; the last three have side effects
   localparam logic [15:0] OFS_ALL [18] = '{OFS_DEST, OFS_SIZE,
      OFS_SRC_ERR, OFS_SRC_COLOR, OFS_PAT_COL01, OFS_PAT_COL23, OFS_PAT_W0,
      OFS_PAT_W1, OFS_PAT_W2, OFS_PAT_W3, OFS_VGA_WR, OFS_VGA_RD, OFS_RASTER,
      OFS_VGA_BASE, OFS_VGA_LATCH, OFS_VECTOR, OFS_BLT, OFS_STATE};
   localparam logic [7:0]  ROPS [5] = '{8'hf0, 8'hcc, 8'h5a, 8'h66, 8'h55};

   graphics_pipe_register_bank u_dut (
      .core_clk, .rst, .wr_en, .rd_en, .addr, .wdata, .rdata, .rd_valid,
      .engine_done, .latch_load, .latch_in, .pat_pix, .src_pix, .dst_pix,
      .rop_pix, .vector_start, .blt_start, .engine_busy, .dest_y, .dest_x,
      .geom_size, .geom_src, .src_colors, .pat_colors, .pattern,
      .color_pattern, .raster_mode, .vga_wr_ctrl, .vga_rd_ctrl, .vga_base,
      .vga_latch
   );

   // Free-running core clock
   always #5 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////
   // Galois shift register, so every run sees the same values
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c1_1db7 : 32'h0);
      return lfsr;
   endfunction

   // Expected output word for each plain register
   function automatic logic [31:0] port_val(input logic [15:0] a);
      case (a)
         OFS_DEST:      return {dest_y, dest_x};
         OFS_SIZE:      return geom_size;
         OFS_SRC_ERR:   return geom_src;
         OFS_SRC_COLOR: return src_colors;
         OFS_PAT_COL01: return pat_colors[31:0];
         OFS_PAT_COL23: return pat_colors[63:32];
         OFS_PAT_W0:    return pattern[31:0];
         OFS_PAT_W1:    return pattern[63:32];
         OFS_PAT_W2:    return pattern[95:64];
         OFS_PAT_W3:    return pattern[127:96];
         OFS_VGA_WR:    return vga_wr_ctrl;
         OFS_VGA_RD:    return vga_rd_ctrl;
         OFS_RASTER:    return raster_mode;
         OFS_VGA_BASE:  return vga_base;
         default:       return vga_latch;
      endcase
   endfunction

   // Each output bit picks one code bit: pattern, source, destination
   function automatic logic [15:0] rop_exp(input logic [7:0] c,
      input logic [15:0] p, input logic [15:0] s, input logic [15:0] d);
      logic [15:0] r;
      for (int i = 0; i < 16; i++)
         r[i] = c[{p[i], s[i], d[i]}];
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge core_clk);
      #1;
      wr_en = 1'b1;
      addr  = a;
      wdata = d;
      @(posedge core_clk);
      #1;
      wr_en = 1'b0;
   endtask

   // Read data stands one cycle only, so it is taken right after the edge
   task automatic chk_rd(input logic [15:0] a, input logic [31:0] e);
      @(posedge core_clk);
      #1;
      rd_en = 1'b1;
      addr  = a;
      @(posedge core_clk);
      #1;
      rd_en = 1'b0;
      `CHK(rd_valid, 1'b1)
      `CHK(rdata, e)
   endtask

   // Launch an operation; status low byte is busy, line, block
   task automatic launch(input logic [15:0] a, input logic [7:0] st,
      input logic fin);
      logic [31:0] v;
      v = rnd();
      wr(a, v);
      `CHK({blt_start, vector_start, engine_busy}, {st[2:1], 1'b1})
      chk_rd(a, v);
      `CHK({vector_start, blt_start}, 2'b00)
      chk_rd(OFS_STATE, {cfg[31:8], st});
      if (fin) begin
         @(posedge core_clk);
         #1;
         engine_done = 1'b1;
         @(posedge core_clk);
         #1;
         engine_done = 1'b0;
         `CHK(engine_busy, 1'b0)
         chk_rd(OFS_STATE, {cfg[31:8], 8'h00});
      end
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Whole run is well under a thousand cycles
   initial begin
      #50_000;
      n_fail++;
      conclude();
   end

   initial begin
      logic [31:0] d;
      repeat (4) @(posedge core_clk);
      #1;
      rst = 1'b0;
      foreach (OFS_ALL[i])
         chk_rd(OFS_ALL[i], REG_RESET);
      repeat (2)
         for (int i = 0; i < 15; i++) begin
            d = rnd();
            wr(OFS_ALL[i], d);
            `CHK(port_val(OFS_ALL[i]), d)
            chk_rd(OFS_ALL[i], d);
         end
      // Coordinates are signed: a top bit set must read as negative
      wr(OFS_DEST, 32'h8001_7fff);
      `CHK(dest_y < 16'sh0000, 1'b1)
      `CHK(dest_x, 16'sh7fff)
      // Unmapped hole inside the window keeps nothing
      wr(16'h8118, rnd());
      chk_rd(16'h8118, 32'h0000_0000);
      cfg = rnd();
      wr(OFS_STATE, cfg);
      launch(OFS_VECTOR, 8'h03, 1'b1);
      launch(OFS_BLT, 8'h05, 1'b1);
      launch(OFS_VECTOR, 8'h03, 1'b0);
      launch(OFS_BLT, 8'h05, 1'b1);
      // Common codes first, then random ones; odd passes vary the mode
      for (int i = 0; i < 12; i++) begin
         d = rnd();
         if (i < 5)
            d[7:0] = ROPS[i];
         if (i % 2 == 0)
            d[9:8] = PAT_MODE_COLOR;
         wr(OFS_RASTER, d);
         `CHK(color_pattern, d[9:8] == 2'b11)
         repeat (4) begin
            pat_pix = 16'(rnd());
            src_pix = 16'(rnd());
            dst_pix = 16'(rnd());
            @(posedge core_clk);
            #1;
            `CHK(rop_pix, rop_exp(d[7:0], pat_pix, src_pix, dst_pix))
         end
      end
      @(posedge core_clk);
      #1;
      latch_load = 1'b1;
      latch_in   = rnd();
      @(posedge core_clk);
      #1;
      latch_load = 1'b0;
      `CHK(vga_latch, latch_in)
      chk_rd(OFS_VGA_LATCH, latch_in);
      // Second reset in mid-run clears the stored state again
      rst = 1'b1;
      @(posedge core_clk);
      #1;
      rst = 1'b0;
      chk_rd(OFS_VGA_LATCH, REG_RESET);
      conclude();
   end

   `undef CHK
endmodule
`default_nettype wire
